// >>> common/ubec_pkg.sv
package ubec_pkg;

  // Widths and fixed figures of the bit-clock generator.
  localparam int DIV_W = 16;
  localparam int ETU_W = 11;
  localparam int FRAC_W = 3;
  localparam int FRAC_STEPS = 8;
  localparam int PRESCALE_DIV = 8;
  localparam logic [ETU_W-1:0] ETU_RATIO_RST = 11'h174;
  localparam logic [3:0] OVER8_LAST = 4'h7;
  localparam logic [3:0] OVER16_LAST = 4'hf;

  // Serial clock may be at most the master clock divided by 4.5 (in tenths).
  localparam int SYNC_MIN_RATIO_X10 = 45;
  localparam int SYNC_MIN_CYC = (SYNC_MIN_RATIO_X10 + 9) / 10;
  localparam logic [DIV_W:0] SYNC_MIN_PERIOD = (DIV_W+1)'(SYNC_MIN_CYC);

  // Clock source select encodings.
  localparam logic [1:0] SRC_MASTER = 2'h0;
  localparam logic [1:0] SRC_PRESCALED = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;

  typedef enum logic [1:0] {
    UBEC_ASYNC,
    UBEC_SYNC,
    UBEC_ISO
  } ubec_mode_t;

  typedef enum logic [1:0] {
    UBEC_OFF,
    UBEC_ON,
    UBEC_DRAIN
  } ubec_side_t;

  typedef struct packed {
    ubec_mode_t mode;
    logic normal_mode;
    logic over;
    logic [1:0] clk_source_select;
    logic clock_output_enable;
    logic [DIV_W-1:0] clock_divisor;
    logic [FRAC_W-1:0] frac_part;
  } ubec_cfg_t;

  typedef struct packed {
    logic rx_enable_cmd;
    logic rx_disable_cmd;
    logic rx_soft_reset;
    logic tx_enable_cmd;
    logic tx_disable_cmd;
    logic tx_soft_reset;
  } ubec_cmd_t;

endpackage : ubec_pkg

// >>> hdl/ubec_top.sv
`timescale 1ns/1ps
`default_nettype none

module ubec_top #(
  parameter int PRESCALE = ubec_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Configuration
  input wire ubec_pkg::ubec_cfg_t CFG_I,
  input wire logic ETU_WR_I,
  input wire logic [ubec_pkg::ETU_W-1:0] ETU_WDATA_I,
  // Control commands
  input wire logic CTRL_WR_I,
  input wire ubec_pkg::ubec_cmd_t CMD_I,
  // Character engine status
  input wire logic RX_BUSY_I,
  input wire logic TX_BUSY_I,
  input wire logic TX_HOLD_FULL_I,
  // Serial clock pin
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_O,
  // Enables and soft resets
  output logic RX_EN_O,
  output logic TX_EN_O,
  output logic RX_SRST_O,
  output logic TX_SRST_O,
  // Bit clock
  output logic SAMPLE_TICK_O,
  output logic BAUD_TICK_O,
  output logic [ubec_pkg::ETU_W-1:0] ETU_RATIO_O
);
  import ubec_pkg::*;

  if (PRESCALE < 2 || PRESCALE > 256)
  begin : g_bad_prescale
    $error("PRESCALE must lie in 2..256");
  end

  typedef struct packed {
    logic sck_meta;
    logic sck_sync;
    logic sck_prev;
    logic [7:0] pre_cnt;
    logic [DIV_W:0] cd_cnt;
    logic [FRAC_W-1:0] frac_acc;
    logic frac_extra;
    logic [3:0] over_cnt;
    logic [ETU_W-1:0] etu_cnt;
    logic [ETU_W-1:0] etu_ratio;
    ubec_side_t rx_st;
    ubec_side_t tx_st;
    logic rx_srst;
    logic tx_srst;
    logic sample_tick;
    logic baud_tick;
    logic sck_pos;
  } ubec_state_t;

  localparam ubec_state_t STATE_RST = '{
    pre_cnt: 8'h00, cd_cnt: '0, frac_acc: '0, over_cnt: 4'h0, etu_cnt: '0,
    etu_ratio: ETU_RATIO_RST, rx_st: UBEC_OFF, tx_st: UBEC_OFF, default: 1'b0};
  localparam logic [7:0] PRE_LAST = 8'(PRESCALE - 1);

  ubec_state_t st_reg;
  ubec_state_t st_next;
  logic sck_neg_reg;
  logic ext_edge;
  logic src_tick;
  logic frac_active;
  logic ext_direct;
  logic sync_master;
  logic odd_master;
  logic cd_tick;
  logic [DIV_W:0] period;

  // Shared next-state of one side; reset beats disable, disable beats enable.
  function automatic ubec_side_t side_next(input ubec_side_t cur, input logic wr,
                                           input logic en, input logic dis,
                                           input logic rst, input logic busy);
    ubec_side_t nxt;
    nxt = cur;
    if (cur == UBEC_DRAIN && !busy)
      nxt = UBEC_OFF;
    if (wr && rst)
      nxt = UBEC_OFF;
    else if (wr && dis)
      nxt = (cur == UBEC_OFF || !busy) ? UBEC_OFF : UBEC_DRAIN;
    else if (wr && en)
      nxt = UBEC_ON;
    return nxt;
  endfunction : side_next

  always_comb
  begin
    st_next = st_reg;
    // The pin is read only through the second synchroniser stage.
    st_next.sck_meta = SCK_I;
    st_next.sck_sync = st_reg.sck_meta;
    st_next.sck_prev = st_reg.sck_sync;
    ext_edge = st_reg.sck_sync && !st_reg.sck_prev;

    st_next.pre_cnt = (st_reg.pre_cnt >= PRE_LAST) ? 8'h00 : st_reg.pre_cnt + 8'h01;
    case (CFG_I.clk_source_select)
      SRC_MASTER: src_tick = 1'b1;
      SRC_PRESCALED: src_tick = (st_reg.pre_cnt == PRE_LAST);
      SRC_EXTERNAL: src_tick = ext_edge;
      default: src_tick = 1'b0;
    endcase

    frac_active = CFG_I.mode == UBEC_ASYNC && CFG_I.normal_mode && CFG_I.frac_part != '0;
    ext_direct = CFG_I.mode == UBEC_SYNC && CFG_I.clk_source_select == SRC_EXTERNAL;
    sync_master = CFG_I.mode == UBEC_SYNC && CFG_I.clock_output_enable
                  && (CFG_I.clk_source_select == SRC_MASTER
                      || CFG_I.clk_source_select == SRC_PRESCALED);
    period = {1'b0, CFG_I.clock_divisor} + {{DIV_W{1'b0}}, frac_active && st_reg.frac_extra};
    if (sync_master && CFG_I.clock_divisor != '0 && period < SYNC_MIN_PERIOD)
      period = SYNC_MIN_PERIOD;

    // A divisor of 0 stops the clock; a period of 1 passes every source tick.
    cd_tick = 1'b0;
    if (CFG_I.clock_divisor == '0)
      st_next.cd_cnt = '0;
    else if (src_tick)
    begin
      if (st_reg.cd_cnt >= period - 1'b1)
      begin
        cd_tick = 1'b1;
        st_next.cd_cnt = '0;
      end
      else
        st_next.cd_cnt = st_reg.cd_cnt + 1'b1;
    end

    // Carrying eighths stretches one period in eight per step of the fraction.
    if (!frac_active)
    begin
      st_next.frac_acc = '0;
      st_next.frac_extra = 1'b0;
    end
    else if (cd_tick)
      {st_next.frac_extra, st_next.frac_acc} = {1'b0, st_reg.frac_acc} + {1'b0, CFG_I.frac_part};

    st_next.sample_tick = cd_tick;
    st_next.baud_tick = 1'b0;
    case (CFG_I.mode)
      UBEC_ASYNC:
      begin
        if (cd_tick)
        begin
          if (st_reg.over_cnt >= (CFG_I.over ? OVER8_LAST : OVER16_LAST))
          begin
            st_next.over_cnt = 4'h0;
            st_next.baud_tick = 1'b1;
          end
          else
            st_next.over_cnt = st_reg.over_cnt + 4'h1;
        end
      end
      UBEC_SYNC:
      begin
        st_next.over_cnt = 4'h0;
        st_next.sample_tick = ext_direct ? ext_edge : cd_tick;
        st_next.baud_tick = ext_direct ? ext_edge : cd_tick;
      end
      UBEC_ISO:
      begin
        st_next.over_cnt = 4'h0;
        if (cd_tick && st_reg.etu_ratio != '0)
        begin
          if (st_reg.etu_cnt >= st_reg.etu_ratio - 1'b1)
          begin
            st_next.etu_cnt = '0;
            st_next.baud_tick = 1'b1;
          end
          else
            st_next.etu_cnt = st_reg.etu_cnt + 1'b1;
        end
      end
      default:
        st_next.over_cnt = 4'h0;
    endcase
    if (CFG_I.mode != UBEC_ISO)
      st_next.etu_cnt = '0;
    if (ETU_WR_I)
      st_next.etu_ratio = ETU_WDATA_I;

    // Divided clock is high for the first half of each period.
    st_next.sck_pos = CFG_I.clock_divisor != '0
                      && st_next.cd_cnt < {1'b0, period[DIV_W:1]};
    odd_master = CFG_I.clk_source_select == SRC_MASTER && period[0];

    // Both sides decide from one command write, each on its own fields.
    st_next.rx_st = side_next(st_reg.rx_st, CTRL_WR_I, CMD_I.rx_enable_cmd,
                              CMD_I.rx_disable_cmd, CMD_I.rx_soft_reset, RX_BUSY_I);
    st_next.tx_st = side_next(st_reg.tx_st, CTRL_WR_I, CMD_I.tx_enable_cmd,
                              CMD_I.tx_disable_cmd, CMD_I.tx_soft_reset,
                              TX_BUSY_I || TX_HOLD_FULL_I);
    st_next.rx_srst = CTRL_WR_I && CMD_I.rx_soft_reset;
    st_next.tx_srst = CTRL_WR_I && CMD_I.tx_soft_reset;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
      st_reg <= STATE_RST;
    else
      st_reg <= st_next;
  end

  // Half-cycle stretch of the high phase makes an odd master-clock divisor
  // symmetric; a period of 1 cannot be stretched and leaves the pin low.
  always_ff @(negedge CLK_I)
  begin
    if (!RESETN_I)
      sck_neg_reg <= 1'b0;
    else
      sck_neg_reg <= st_reg.sck_pos;
  end

  assign SCK_O = st_reg.sck_pos || (odd_master && sck_neg_reg);
  assign SCK_OE_O = CFG_I.clock_output_enable && CFG_I.mode != UBEC_ASYNC
                    && CFG_I.clk_source_select != SRC_EXTERNAL;
  assign RX_EN_O = st_reg.rx_st != UBEC_OFF;
  assign TX_EN_O = st_reg.tx_st != UBEC_OFF;
  assign RX_SRST_O = st_reg.rx_srst;
  assign TX_SRST_O = st_reg.tx_srst;
  assign SAMPLE_TICK_O = st_reg.sample_tick;
  assign BAUD_TICK_O = st_reg.baud_tick;
  assign ETU_RATIO_O = st_reg.etu_ratio;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  // Command and write checks look one cycle after the edge that takes them; reset checks look at the first edge out of reset.
  a_reset_sides_off: assert property ($rose(RESETN_I) |-> !RX_EN_O && !TX_EN_O)
    else $error("side enabled straight after reset");
  a_reset_tx_off: assert property ($rose(RESETN_I) |-> !TX_EN_O && !TX_SRST_O)
    else $error("transmitter active after reset");
  a_etu_reset_val: assert property ($rose(RESETN_I) |-> ETU_RATIO_O == ETU_RATIO_RST)
    else $error("time-unit ratio reset value wrong");
  a_etu_write_take: assert property (ETU_WR_I |=> ETU_RATIO_O == $past(ETU_WDATA_I))
    else $error("time-unit ratio write lost");
  a_rx_enable_take: assert property (
    CTRL_WR_I && CMD_I.rx_enable_cmd && !CMD_I.rx_disable_cmd && !CMD_I.rx_soft_reset
    |=> RX_EN_O)
    else $error("receive enable not taken");
  a_tx_enable_take: assert property (
    CTRL_WR_I && CMD_I.tx_enable_cmd && !CMD_I.tx_disable_cmd && !CMD_I.tx_soft_reset
    |=> TX_EN_O)
    else $error("transmit enable not taken");
  a_soft_reset_stop: assert property (
    CTRL_WR_I && CMD_I.rx_soft_reset
    |=> (!RX_EN_O && RX_SRST_O) ##1 (RX_SRST_O == $past(CTRL_WR_I && CMD_I.rx_soft_reset)))
    else $error("receive soft reset did not stop side");
  a_disable_priority: assert property (
    CTRL_WR_I && CMD_I.tx_enable_cmd && CMD_I.tx_disable_cmd && !CMD_I.tx_soft_reset
    && !TX_BUSY_I && !TX_HOLD_FULL_I |=> !TX_EN_O)
    else $error("enable won over disable");
  a_rx_drain_hold: assert property (
    RX_EN_O && CTRL_WR_I && CMD_I.rx_disable_cmd && !CMD_I.rx_soft_reset && RX_BUSY_I
    |=> RX_EN_O)
    else $error("receiver stopped mid character");
  a_tx_drain_hold: assert property (
    TX_EN_O && CTRL_WR_I && CMD_I.tx_disable_cmd && !CMD_I.tx_soft_reset
    && (TX_BUSY_I || TX_HOLD_FULL_I) |=> TX_EN_O)
    else $error("transmitter stopped with a character pending");
  a_divisor_zero: assert property (
    $past(CFG_I.clock_divisor == '0 && !ext_direct) |-> !SAMPLE_TICK_O && !BAUD_TICK_O)
    else $error("tick with divisor zero");
  a_sync_ext_pass: assert property ($past(ext_direct && ext_edge) |-> BAUD_TICK_O)
    else $error("external clock edge not passed through");
  a_sync_min_gap: assert property (
    BAUD_TICK_O && $past(sync_master) && sync_master && $stable(CFG_I)
    |=> !BAUD_TICK_O [*4])
    else $error("sync master bit clock faster than limit");

endmodule : ubec_top

`default_nettype wire

// >>> test/ubec_peer.sv
`timescale 1ns/1ps
`default_nettype none

// Remote party that supplies the serial clock; it rests low between frames.
module ubec_peer #(
  parameter int HALF_NS = 50
) (
  // Frame control
  input wire logic run_i,
  // Serial clock
  output logic sck_o
);
  logic level = 1'b0;

  // Ten master cycles a period keeps far beyond the 4.5 ratio.
  always
  begin
    #(HALF_NS);
    level = run_i ? ~level : 1'b0;
  end
  assign sck_o = level;
endmodule : ubec_peer

`default_nettype wire

// >>> test/test_usart_baud_and_enable_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_usart_baud_and_enable_control;
  import ubec_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  ubec_cfg_t cfg = '0;
  logic etu_wr = 1'b0;
  logic [ETU_W-1:0] etu_data = '0;
  logic ctrl_wr = 1'b0;
  ubec_cmd_t cmd = '0;
  logic rx_busy = 1'b0;
  logic tx_busy = 1'b0;
  logic tx_full = 1'b0;
  logic peer_run = 1'b0;
  logic peer_sck;
  wire logic sck_pin;
  logic sck_o, sck_oe, rx_en, tx_en, rx_srst, tx_srst, stick, btick;
  logic [ETU_W-1:0] etu_ratio;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  int hi;

  always #5 clk = ~clk;
  // The pin carries whoever drives it; the peer only while the block listens.
  assign sck_pin = sck_oe ? sck_o : peer_sck;

  ubec_peer u_ubec_peer (.run_i(peer_run), .sck_o(peer_sck));

  ubec_top u_ubec_top (
    .CLK_I(clk), .RESETN_I(resetn), .CFG_I(cfg), .ETU_WR_I(etu_wr),
    .ETU_WDATA_I(etu_data), .CTRL_WR_I(ctrl_wr), .CMD_I(cmd),
    .RX_BUSY_I(rx_busy), .TX_BUSY_I(tx_busy), .TX_HOLD_FULL_I(tx_full),
    .SCK_I(sck_pin), .SCK_O(sck_o), .SCK_OE_O(sck_oe), .RX_EN_O(rx_en),
    .TX_EN_O(tx_en), .RX_SRST_O(rx_srst), .TX_SRST_O(tx_srst),
    .SAMPLE_TICK_O(stick), .BAUD_TICK_O(btick), .ETU_RATIO_O(etu_ratio)
  );

  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic send(input ubec_cmd_t c);
    @(posedge clk);
    ctrl_wr <= 1'b1;
    cmd <= c;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    @(negedge clk);
  endtask : send

  task automatic set_etu(input logic [ETU_W-1:0] v);
    @(posedge clk);
    etu_wr <= 1'b1;
    etu_data <= v;
    @(posedge clk);
    etu_wr <= 1'b0;
    @(negedge clk);
  endtask : set_etu

  // Cycles between two bit ticks; 200 means no tick at all.
  task automatic period(output int p);
    int i;
    p = 0;
    for (i = 0; i < 200 && btick !== 1'b1; i++)
      @(negedge clk);
    for (i = 0; i < 200; i++)
    begin
      @(negedge clk);
      p++;
      if (btick === 1'b1)
        break;
    end
  endtask : period

  task automatic setcfg(input ubec_mode_t m, input logic nm, input logic ov,
                        input logic [1:0] src, input logic oe,
                        input logic [DIV_W-1:0] d, input logic [FRAC_W-1:0] f);
    @(posedge clk);
    cfg <= '{m, nm, ov, src, oe, d, f};
    period(n);
  endtask : setcfg

  task automatic t_reset();
    chk(rx_en === 1'b0 && tx_en === 1'b0, "side on after reset");
    chk(etu_ratio === ETU_RATIO_RST, "ratio reset value");
    set_etu(11'h7ff);
    chk(etu_ratio === 11'h7ff, "ratio write while off");
  endtask : t_reset

  task automatic t_enables();
    send(6'h20);
    chk(rx_en === 1'b1 && tx_en === 1'b0, "rx alone");
    send(6'h04);
    chk(tx_en === 1'b1 && rx_en === 1'b1, "tx added");
    send(6'h12);
    @(negedge clk);
    chk(rx_en === 1'b0 && tx_en === 1'b0, "idle disable");
    send(6'h36);
    chk(rx_en === 1'b0 && tx_en === 1'b0, "disable must win");
    send(6'h24);
    chk(rx_en === 1'b1 && tx_en === 1'b1, "both in one write");
  endtask : t_enables

  task automatic t_drain();
    @(posedge clk);
    rx_busy <= 1'b1;
    tx_full <= 1'b1;
    send(6'h12);
    repeat (3) @(negedge clk);
    chk(rx_en === 1'b1 && tx_en === 1'b1, "stopped mid character");
    @(posedge clk);
    rx_busy <= 1'b0;
    tx_full <= 1'b0;
    repeat (2) @(negedge clk);
    chk(rx_en === 1'b0 && tx_en === 1'b0, "drain not ended");
  endtask : t_drain

  task automatic t_srst();
    send(6'h24);
    @(posedge clk);
    rx_busy <= 1'b1;
    send(6'h09);
    chk(rx_srst === 1'b1 && tx_srst === 1'b1, "no soft reset pulse");
    chk(rx_en === 1'b0 && tx_en === 1'b0, "not stopped at once");
    @(negedge clk);
    chk(rx_srst === 1'b0 && tx_srst === 1'b0, "pulse too long");
    chk(etu_ratio === 11'h7ff, "config lost");
    @(posedge clk);
    rx_busy <= 1'b0;
  endtask : t_srst

  task automatic t_async();
    setcfg(UBEC_ASYNC, 1'b1, 1'b1, SRC_MASTER, 1'b0, 16'h0002, 3'h0);
    period(n);
    chk(n == 16, "over 8 period");
    hi = 0;
    repeat (16)
    begin
      @(negedge clk);
      if (stick === 1'b1)
        hi++;
    end
    chk(hi == 8, "sample ticks per bit");
    setcfg(UBEC_ASYNC, 1'b1, 1'b0, SRC_MASTER, 1'b0, 16'h0002, 3'h0);
    period(n);
    chk(n == 32, "over 16 period");
    setcfg(UBEC_ASYNC, 1'b1, 1'b1, SRC_MASTER, 1'b0, 16'h0002, 3'h4);
    period(n);
    chk(n == 20, "fraction period");
    setcfg(UBEC_ASYNC, 1'b0, 1'b1, SRC_MASTER, 1'b0, 16'h0002, 3'h4);
    period(n);
    chk(n == 16, "fraction outside normal mode");
  endtask : t_async

  task automatic t_sync();
    setcfg(UBEC_SYNC, 1'b1, 1'b0, SRC_MASTER, 1'b0, 16'h0006, 3'h0);
    period(n);
    chk(n == 6, "sync divide");
    setcfg(UBEC_SYNC, 1'b1, 1'b0, SRC_MASTER, 1'b1, 16'h0002, 3'h0);
    period(n);
    chk(n == 5, "master clock too fast");
    setcfg(UBEC_SYNC, 1'b1, 1'b0, SRC_MASTER, 1'b1, 16'h0005, 3'h0);
    hi = 0;
    // Sampling half a step off the grid keeps clear of both clock edges.
    #0.5;
    repeat (50)
    begin
      #1;
      if (sck_o === 1'b1)
        hi++;
    end
    chk(hi == 25 && sck_oe === 1'b1, "odd divisor duty");
    setcfg(UBEC_SYNC, 1'b1, 1'b0, SRC_MASTER, 1'b0, 16'h0000, 3'h0);
    period(n);
    chk(n == 200, "divisor zero ticks");
    peer_run <= 1'b1;
    setcfg(UBEC_SYNC, 1'b1, 1'b0, SRC_EXTERNAL, 1'b0, 16'h0000, 3'h0);
    period(n);
    chk(n == 10, "pin clock period");
    peer_run <= 1'b0;
  endtask : t_sync

  task automatic t_iso();
    // Software takes the truncated integer quotient of the two factors.
    set_etu(11'(372 / 12));
    setcfg(UBEC_ISO, 1'b1, 1'b0, SRC_MASTER, 1'b1, 16'h0002, 3'h0);
    period(n);
    chk(n == 62 && sck_oe === 1'b1, "time unit period");
  endtask : t_iso

  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    t_reset();
    t_enables();
    t_drain();
    t_srst();
    t_async();
    t_sync();
    t_iso();
    end_of_test();
  end
endmodule : test_usart_baud_and_enable_control

`default_nettype wire
